/* File: src/dit_pkg.sv */
// package: register map, field layout, reset values and prescale codes of the interval timer pair
package dit_pkg;

  // ==========================================================
  // register addresses
  localparam logic [15:0] ADDR_PORT_FUNC = 16'hFE42;
  localparam logic [15:0] ADDR_PAIR_CTRL = 16'hFE78;
  localparam logic [15:0] ADDR_FIRST_PERIOD = 16'hFE7A;
  localparam logic [15:0] ADDR_SECOND_PERIOD = 16'hFE7B;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFE7C;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hFE7D;

  // ==========================================================
  // control and port function register fields
  localparam int CTRL_FIRST_IE = 0;
  localparam int CTRL_FIRST_OV = 1;
  localparam int CTRL_SECOND_IE = 2;
  localparam int CTRL_SECOND_OV = 3;
  localparam int CTRL_FIRST_SEL = 4;
  localparam int CTRL_SECOND_SEL = 6;
  localparam int FUNC_FIRST_OE = 6;
  localparam int FUNC_SECOND_OE = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PAIR_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_PORT_FUNC = 8'h00;
  localparam logic [7:0] FUNC_ONES = 8'h30;
  localparam logic [1:0] RST_MASK = 2'h0;

  // ==========================================================
  // prescale codes and terminal counts
  localparam logic [1:0] SEL_STOP = 2'h0;
  localparam logic [1:0] SEL_DIV4 = 2'h1;
  localparam logic [1:0] SEL_DIV16 = 2'h2;
  localparam logic [1:0] SEL_DIV64 = 2'h3;
  localparam logic [5:0] LAST_DIV4 = 6'h03;
  localparam logic [5:0] LAST_DIV16 = 6'h0F;
  localparam logic [5:0] LAST_DIV64 = 6'h3F;

  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] period;
    logic restart;
  } dit_timer_cfg_s;

endpackage : dit_pkg

/* File: src/dit_prescaler.sv */
// 6-bit prescaler giving a one-cycle tick every 4, 16 or 64 cycles
`timescale 1ns/10ps
module dit_prescaler (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] sel,
  input wire logic restart,
  output logic tick
);
  logic [5:0] count;
  logic [5:0] last;

  // ==========================================================
  // terminal count per code
  always_comb begin
    case (sel)
      dit_pkg::SEL_DIV4: last = dit_pkg::LAST_DIV4;
      dit_pkg::SEL_DIV16: last = dit_pkg::LAST_DIV16;
      dit_pkg::SEL_DIV64: last = dit_pkg::LAST_DIV64;
      default: last = dit_pkg::LAST_DIV64;
    endcase
  end

  // stop code holds the prescaler in reset
  always_ff @(posedge clock) begin
    if (rst || restart || sel == dit_pkg::SEL_STOP) begin
      count <= 6'h00;
    end else if (count == last) begin
      count <= 6'h00;
    end else begin
      count <= count + 6'h01;
    end
  end

  assign tick = (sel != dit_pkg::SEL_STOP) && !restart && (count == last);

endmodule : dit_prescaler

/* File: src/dit_counter.sv */
// 8-bit interval counter that wraps after its period value and toggles a waveform
`timescale 1ns/10ps
module dit_counter (
  input wire logic clock,
  input wire logic rst,
  input wire dit_pkg::dit_timer_cfg_s cfg,
  output logic [7:0] count,
  output logic wrap,
  output logic toggle
);
  logic tick;

  dit_prescaler u_pre (
    .clock(clock),
    .rst(rst),
    .sel(cfg.sel),
    .restart(cfg.restart),
    .tick(tick)
  );

  // ==========================================================
  // counter
  assign wrap = tick && (count == cfg.period);

  always_ff @(posedge clock) begin
    if (rst || cfg.restart || cfg.sel == dit_pkg::SEL_STOP) begin
      count <= 8'h00;
    end else if (wrap) begin
      count <= 8'h00;
    end else if (tick) begin
      count <= count + 8'h01;
    end
  end

  // waveform keeps its level while stopped
  always_ff @(posedge clock) begin
    if (rst) begin
      toggle <= 1'b0;
    end else if (wrap) begin
      toggle <= ~toggle;
    end
  end

endmodule : dit_counter

/* File: src/dit_timer_pair.sv */
// top of the dual interval timer with toggle outputs and register port
`timescale 1ns/10ps
module dit_timer_pair (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] address,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [7:0] readData,
  input wire logic [1:0] portLatch,
  output logic firstTogglePin,
  output logic secondTogglePin,
  output logic irq,
  output logic [1:0] eventIrq
);
  logic [7:0] pairControl;
  logic [7:0] firstPeriod;
  logic [7:0] secondPeriod;
  logic [7:0] portFunction;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [7:0] firstCount;
  logic [7:0] secondCount;
  logic firstWrap;
  logic secondWrap;
  logic firstToggle;
  logic secondToggle;
  logic firstRunning;
  logic secondRunning;
  dit_pkg::dit_timer_cfg_s firstCfg;
  dit_pkg::dit_timer_cfg_s secondCfg;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction : hit

  // ==========================================================
  // configuration of the two timers
  assign firstRunning = pairControl[dit_pkg::CTRL_FIRST_SEL +: 2] != dit_pkg::SEL_STOP;
  assign secondRunning = pairControl[dit_pkg::CTRL_SECOND_SEL +: 2] != dit_pkg::SEL_STOP;

  always_comb begin
    firstCfg.sel = pairControl[dit_pkg::CTRL_FIRST_SEL +: 2];
    firstCfg.period = firstPeriod;
    firstCfg.restart = writeStrobe && hit(address, dit_pkg::ADDR_FIRST_PERIOD)
      && firstRunning;
    secondCfg.sel = pairControl[dit_pkg::CTRL_SECOND_SEL +: 2];
    secondCfg.period = secondPeriod;
    secondCfg.restart = writeStrobe && hit(address, dit_pkg::ADDR_SECOND_PERIOD)
      && secondRunning;
  end

  // ==========================================================
  // the two timers, identical and independent
  dit_counter u_first (
    .clock(clock),
    .rst(rst),
    .cfg(firstCfg),
    .count(firstCount),
    .wrap(firstWrap),
    .toggle(firstToggle)
  );

  dit_counter u_second (
    .clock(clock),
    .rst(rst),
    .cfg(secondCfg),
    .count(secondCount),
    .wrap(secondWrap),
    .toggle(secondToggle)
  );

  // ==========================================================
  // control register; wrap sets its flag and wins over a software write
  always_ff @(posedge clock) begin
    if (rst) begin
      pairControl <= dit_pkg::RST_PAIR_CTRL;
    end else begin
      if (writeStrobe && hit(address, dit_pkg::ADDR_PAIR_CTRL)) begin
        pairControl <= writeData;
      end
      if (firstWrap) begin
        pairControl[dit_pkg::CTRL_FIRST_OV] <= 1'b1;
      end
      if (secondWrap) begin
        pairControl[dit_pkg::CTRL_SECOND_OV] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      firstPeriod <= dit_pkg::RST_PERIOD;
      secondPeriod <= dit_pkg::RST_PERIOD;
      portFunction <= dit_pkg::RST_PORT_FUNC;
    end else if (writeStrobe) begin
      if (hit(address, dit_pkg::ADDR_FIRST_PERIOD)) begin
        firstPeriod <= writeData;
      end
      if (hit(address, dit_pkg::ADDR_SECOND_PERIOD)) begin
        secondPeriod <= writeData;
      end
      if (hit(address, dit_pkg::ADDR_PORT_FUNC)) begin
        portFunction <= writeData & ~dit_pkg::FUNC_ONES;
      end
    end
  end

  // ==========================================================
  // event status (write one to clear, set wins) and mask
  always_ff @(posedge clock) begin
    if (rst) begin
      irqStatus <= 2'h0;
      irqMask <= dit_pkg::RST_MASK;
    end else begin
      if (writeStrobe && hit(address, dit_pkg::ADDR_IRQ_MASK)) begin
        irqMask <= writeData[1:0];
      end
      irqStatus[0] <= firstWrap || (irqStatus[0] &&
        !(writeStrobe && hit(address, dit_pkg::ADDR_IRQ_STATUS) && writeData[0]));
      irqStatus[1] <= secondWrap || (irqStatus[1] &&
        !(writeStrobe && hit(address, dit_pkg::ADDR_IRQ_STATUS) && writeData[1]));
    end
  end

  assign eventIrq = irqStatus & irqMask;

  // ==========================================================
  // shared interrupt request
  assign irq = (pairControl[dit_pkg::CTRL_FIRST_OV] && pairControl[dit_pkg::CTRL_FIRST_IE])
    || (pairControl[dit_pkg::CTRL_SECOND_OV] && pairControl[dit_pkg::CTRL_SECOND_IE]);

  // ==========================================================
  // pin outputs; pin direction lives in the port block, these are the output values
  always_ff @(posedge clock) begin
    if (rst) begin
      firstTogglePin <= 1'b0;
      secondTogglePin <= 1'b0;
    end else begin
      firstTogglePin <= portLatch[0] |
        (portFunction[dit_pkg::FUNC_FIRST_OE] & firstToggle);
      secondTogglePin <= portLatch[1] |
        (portFunction[dit_pkg::FUNC_SECOND_OE] & secondToggle);
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clock) begin
    if (rst) begin
      readData <= 8'h00;
    end else if (readStrobe) begin
      case (address)
        dit_pkg::ADDR_PAIR_CTRL: readData <= pairControl;
        dit_pkg::ADDR_FIRST_PERIOD: readData <= firstPeriod;
        dit_pkg::ADDR_SECOND_PERIOD: readData <= secondPeriod;
        dit_pkg::ADDR_PORT_FUNC: readData <= portFunction | dit_pkg::FUNC_ONES;
        dit_pkg::ADDR_IRQ_STATUS: readData <= {6'h00, irqStatus};
        dit_pkg::ADDR_IRQ_MASK: readData <= {6'h00, irqMask};
        default: readData <= 8'h00;
      endcase
    end else begin
      readData <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  a_first_held_zero: assert property (@(posedge clock) disable iff (rst)
    !firstRunning |=> firstCount == 8'h00) else $error("first counter not held");
  a_second_held_zero: assert property (@(posedge clock) disable iff (rst)
    !secondRunning |=> secondCount == 8'h00) else $error("second counter not held");
  a_first_wrap_flag: assert property (@(posedge clock) disable iff (rst)
    firstWrap |=> pairControl[dit_pkg::CTRL_FIRST_OV] && firstCount == 8'h00)
    else $error("first wrap lost");
  a_second_wrap_flag: assert property (@(posedge clock) disable iff (rst)
    secondWrap |=> pairControl[dit_pkg::CTRL_SECOND_OV] && secondCount == 8'h00)
    else $error("second wrap lost");
  a_first_restart: assert property (@(posedge clock) disable iff (rst)
    firstCfg.restart |=> firstCount == 8'h00 && !firstWrap) else $error("no restart");
  a_second_restart: assert property (@(posedge clock) disable iff (rst)
    secondCfg.restart |=> secondCount == 8'h00 && !secondWrap)
    else $error("no restart");
  a_first_div4: assert property (@(posedge clock) disable iff (rst)
    pairControl[5:4] == dit_pkg::SEL_DIV4 && firstWrap ##1
    (pairControl[5:4] == dit_pkg::SEL_DIV4 && !firstCfg.restart)[*3] |-> !firstWrap)
    else $error("first tick too fast");
  a_second_div4: assert property (@(posedge clock) disable iff (rst)
    pairControl[7:6] == dit_pkg::SEL_DIV4 && secondWrap ##1
    (pairControl[7:6] == dit_pkg::SEL_DIV4 && !secondCfg.restart)[*3] |-> !secondWrap)
    else $error("second tick too fast");
  a_first_toggle: assert property (@(posedge clock) disable iff (rst)
    firstWrap |=> firstToggle != $past(firstToggle)) else $error("no toggle");
  a_second_toggle: assert property (@(posedge clock) disable iff (rst)
    secondWrap |=> secondToggle != $past(secondToggle)) else $error("no toggle");
  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    irq == ((pairControl[1] && pairControl[0]) || (pairControl[3] && pairControl[2])))
    else $error("irq mismatch");
  a_pin_or: assert property (@(posedge clock) disable iff (rst)
    ##1 firstTogglePin == ($past(portLatch[0]) | ($past(portFunction[6]) & $past(firstToggle))))
    else $error("pin mismatch");

endmodule : dit_timer_pair

/* File: verification/dit_timer_pair_tb.sv */
// self-checking bench for the interval timer pair
`timescale 1ns/10ps
module dit_timer_pair_tb;
  // ==========================================================
  // stimulus and design
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] address = 16'h0000;
  logic [7:0] writeData = 8'h00;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic [1:0] portLatch = 2'h0;
  logic [7:0] readData;
  logic firstTogglePin;
  logic secondTogglePin;
  logic irq;
  logic [1:0] eventIrq;
  int nMismatch = 0;
  int testsRun = 0;
  always #20 clock = ~clock;
  dit_timer_pair uut (.clock(clock), .rst(rst), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .portLatch(portLatch), .firstTogglePin(firstTogglePin),
    .secondTogglePin(secondTogglePin), .irq(irq), .eventIrq(eventIrq));
  // ==========================================================
  // tasks
  task closeOut;
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : closeOut
  task chkVal(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkVal
  task chkCnt(input int got, input int exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkCnt
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe edge
  task rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask : rd
  task waitTog(input int t, output int n);
    logic v;
    v = t ? secondTogglePin : firstTogglePin;
    n = 0;
    while ((t ? secondTogglePin : firstTogglePin) === v) begin
      @(posedge clock);
      #1 n++;
      if (n > 40000) begin
        nMismatch++;
        closeOut();
      end
    end
  endtask : waitTog
  function automatic logic [7:0] ctrlOf(input int t, input int sel, input bit ie);
    return t ? 8'((sel << 6) | (ie << 2)) : 8'((sel << 4) | ie);
  endfunction : ctrlOf
  // ==========================================================
  // sequence
  logic [15:0] addrs [7] = '{16'hFE78, 16'hFE7A, 16'hFE7B, 16'hFE42, 16'hFE7C, 16'hFE7D,
    16'hFE79};
  logic [7:0] rstVals [7] = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00};
  logic [7:0] v;
  logic [7:0] p;
  logic [1:0] mask;
  bit ie;
  int d0, d1, d2;
  initial begin
    void'($urandom(32'h33A7));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(addrs[i], v);
      chkVal(v, rstVals[i]);
    end
    for (int t = 0; t < 2; t++) begin
      for (int sel = 1; sel < 4; sel++) begin
        p = (t == 1 && sel == 1) ? 8'hFF : 8'($urandom_range(3, 15));
        ie = 1'($urandom_range(0, 1));
        mask = 2'($urandom_range(0, 3));
        wr(dit_pkg::ADDR_PORT_FUNC, 8'hC0 | 8'($urandom_range(0, 15)));
        wr(t ? dit_pkg::ADDR_SECOND_PERIOD : dit_pkg::ADDR_FIRST_PERIOD, p);
        wr(dit_pkg::ADDR_IRQ_MASK, {6'h00, mask});
        wr(dit_pkg::ADDR_PAIR_CTRL, ctrlOf(t, sel, ie));
        waitTog(t, d0);
        waitTog(t, d1);
        chkCnt(d1, (int'(p) + 1) << (2 * sel));
        rd(dit_pkg::ADDR_PAIR_CTRL, v);
        chkVal(v, ctrlOf(t, sel, ie) | (t ? 8'h08 : 8'h02));
        chkVal({7'h00, irq}, {7'h00, ie});
        rd(dit_pkg::ADDR_IRQ_STATUS, v);
        chkVal(v, t ? 8'h02 : 8'h01);
        chkVal({6'h00, eventIrq}, {6'h00, v[1:0] & mask});
        // a rewrite halfway through must restart the whole period
        repeat (d1 / 2) @(posedge clock);
        wr(t ? dit_pkg::ADDR_SECOND_PERIOD : dit_pkg::ADDR_FIRST_PERIOD, p);
        waitTog(t, d2);
        chkCnt(d2, d0);
        wr(dit_pkg::ADDR_PAIR_CTRL, 8'h00);
        v = {6'h00, secondTogglePin, firstTogglePin};
        repeat (300) @(posedge clock);
        chkVal({6'h00, secondTogglePin, firstTogglePin}, v);
        chkVal({7'h00, irq}, 8'h00);
        wr(dit_pkg::ADDR_IRQ_STATUS, 8'h03);
        #1 chkVal({6'h00, eventIrq}, 8'h00);
      end
    end
    // nine flips per timer leave both waveforms high
    wr(dit_pkg::ADDR_PORT_FUNC, 8'h05);
    rd(dit_pkg::ADDR_PORT_FUNC, v);
    chkVal(v, 8'h35);
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      portLatch <= 2'(i);
      repeat (2) @(posedge clock);
      chkVal({6'h00, secondTogglePin, firstTogglePin}, 8'(i));
    end
    wr(dit_pkg::ADDR_PORT_FUNC, 8'hC0);
    for (int i = 0; i < 4; i++) begin
      portLatch <= 2'(i);
      repeat (2) @(posedge clock);
      chkVal({6'h00, secondTogglePin, firstTogglePin}, 8'h03);
    end
    closeOut();
  end
endmodule : dit_timer_pair_tb
